// *** verilog/swgc_regs.sv ***
// Purpose: Global control bytes and flush, aging and frame filter control
// Assumes: Table and frame inputs are on MCLK; LINK_UP comes from pins
// Notes:   Table reads answer one cycle after the index is presented
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module swgc_regs #(
    parameter int              NP         = 4,
    parameter int              DYN_DEPTH  = 1024,
    parameter int              STAT_DEPTH = 32,
    parameter longint unsigned AGE_CYC    = swgc_pkg::AGE_PERIOD_CYC,
    parameter longint unsigned FAST_LIMIT = swgc_pkg::FAST_AGE_MAX_CYC
) (
    input  wire logic                          MCLK,            // System clock
    input  wire logic                          RST_N,           // Async reset
    input  wire logic [7:0]                    ADDR,            // Register address
    input  wire logic [7:0]                    WDATA,           // Write data
    input  wire logic                          WR,              // Write strobe
    input  wire logic                          RD,              // Read strobe
    output logic      [7:0]                    RDATA,           // Read data, next cycle
    output logic                               NEW_BACKOFF_EN,  // Alternative back-off
    output logic                               PASS_ALL_FRAMES, // Debug pass-all
    output logic                               HUGE_FRAME_EN,   // 2K frames allowed
    input  wire logic [NP-1:0]                 LINK_UP,         // Link status pins
    input  wire logic [NP-1:0]                 LEARN_DIS,       // Learning off per port
    output logic                               DYN_RD_EN,       // Dynamic entry read
    output logic [$clog2(DYN_DEPTH)-1:0]       DYN_RD_IDX,      // Dynamic entry index
    input  wire logic                          DYN_ENT_VALID,   // Entry in use
    input  wire logic [$clog2(NP)-1:0]         DYN_ENT_PORT,    // Learned source port
    output logic                               DYN_DEL,         // Remove entry pulse
    output logic [$clog2(DYN_DEPTH)-1:0]       DYN_DEL_IDX,     // Index to remove
    output logic                               STAT_RD_EN,      // Static entry read
    output logic [$clog2(STAT_DEPTH)-1:0]      STAT_RD_IDX,     // Static entry index
    input  wire logic                          STAT_ENT_VALID,  // Entry in use
    input  wire logic [47:0]                   STAT_ENT_MAC,    // Entry address
    input  wire logic [NP-1:0]                 STAT_ENT_PORTS,  // Forward port mask
    output logic                               STAT_DEL,        // Remove entry pulse
    output logic [$clog2(STAT_DEPTH)-1:0]      STAT_DEL_IDX,    // Index to remove
    output logic                               AGE_TICK,        // Normal aging pulse
    input  wire logic                          FRM_VALID,       // Frame verdict request
    input  wire logic [15:0]                   FRM_TYPE,        // Type/length field
    input  wire logic [47:0]                   FRM_DA,          // Destination address
    input  wire logic                          FRM_IS_FC,       // MAC-qualified pause
    input  wire logic                          FRM_BAD,         // Errored frame
    input  wire logic [11:0]                   FRM_LEN,         // Frame length, bytes
    input  wire logic                          SNIFF_EN,        // Sniffer mode on
    output logic                               FRM_DONE,        // Verdict valid pulse
    output logic                               FRM_DROP,        // Discard frame
    output logic                               FRM_SNIFF_BAD    // Mirror bad frame
);
    localparam int DW = $clog2(DYN_DEPTH);
    localparam int SW = $clog2(STAT_DEPTH);
    localparam logic [DW-1:0] DYN_LAST  = DW'(DYN_DEPTH - 1);
    localparam logic [SW-1:0] STAT_LAST = SW'(STAT_DEPTH - 1);

    typedef struct packed {
        logic          new_bo;
        logic          interop_flow_drop_mode;
        logic          link_age;
        logic          pass_all;
        logic          huge;
        logic [NP-1:0] link_m;
        logic [NP-1:0] link_s;
        logic [NP-1:0] link_p;
        logic [7:0]    rdata;
        logic          dyn_pend_flush;
        logic          dyn_pend_age;
        logic          dyn_busy;
        logic          dyn_all;
        logic [DW-1:0] dyn_idx;
        logic          dyn_chk;
        logic [DW-1:0] dyn_chk_idx;
        logic          dyn_del;
        logic [DW-1:0] dyn_del_idx;
        logic          age_restart;
        logic [31:0]   fa_cnt;
        logic          stat_busy;
        logic [SW-1:0] stat_idx;
        logic          stat_chk;
        logic [SW-1:0] stat_chk_idx;
        logic          stat_del;
        logic [SW-1:0] stat_del_idx;
        logic          frm_done;
        logic          frm_drop;
        logic          frm_sniff_bad;
    } swgc_state_t;

    swgc_state_t st_q;
    swgc_state_t st_d;

    logic        wr_gc0;
    logic        dyn_flush_act;
    logic        stat_flush_act;
    logic        fast_age_act;
    logic [NP-1:0] link_fall;
    logic        stat_hit;
    logic        fc_match;
    logic        too_long;
    logic        err_frame;
    logic [11:0] len_max;

    assign wr_gc0         = WR && (ADDR == swgc_pkg::ADDR_GC0);
    assign dyn_flush_act  = st_q.dyn_pend_flush
                          || ((st_q.dyn_busy || st_q.dyn_chk) && !st_q.dyn_all);
    assign stat_flush_act = st_q.stat_busy || st_q.stat_chk;
    assign fast_age_act   = st_q.dyn_pend_age
                          || ((st_q.dyn_busy || st_q.dyn_chk) && st_q.dyn_all);
    assign link_fall      = st_q.link_p & ~st_q.link_s;
    assign stat_hit = STAT_ENT_VALID && !STAT_ENT_MAC[swgc_pkg::MCAST_BIT]
                    && (STAT_ENT_PORTS != '0)
                    && ((STAT_ENT_PORTS & (STAT_ENT_PORTS - NP'(1))) == '0)
                    && ((STAT_ENT_PORTS & LEARN_DIS) != '0);
    assign fc_match = st_q.interop_flow_drop_mode
                    ? ((FRM_TYPE == swgc_pkg::FC_TYPE) || (FRM_DA == swgc_pkg::FC_DA))
                    : FRM_IS_FC;
    assign len_max   = st_q.huge ? swgc_pkg::FRAME_MAX_HUGE : swgc_pkg::FRAME_MAX_STD;
    assign too_long  = FRM_LEN > len_max;
    assign err_frame = FRM_BAD || too_long;

    always_comb
    begin
        st_d             = st_q;
        st_d.link_m      = LINK_UP;
        st_d.link_s      = st_q.link_m;
        st_d.link_p      = st_q.link_s;
        st_d.rdata       = swgc_pkg::RD_UNMAPPED;
        st_d.dyn_del     = 1'b0;
        st_d.stat_del    = 1'b0;
        st_d.age_restart = 1'b0;

        // Register writes; reserved bits have no storage
        if (wr_gc0)
        begin
            st_d.new_bo                 = WDATA[swgc_pkg::GC0_NEW_BO];
            st_d.interop_flow_drop_mode = WDATA[swgc_pkg::GC0_INTEROP];
            st_d.link_age               = WDATA[swgc_pkg::GC0_LINK_AGE];
        end
        if (WR && (ADDR == swgc_pkg::ADDR_GC1))
        begin
            st_d.pass_all = WDATA[swgc_pkg::GC1_PASS_ALL];
            st_d.huge     = WDATA[swgc_pkg::GC1_HUGE];
        end
        if (RD && (ADDR == swgc_pkg::ADDR_GC0))
        begin
            st_d.rdata[swgc_pkg::GC0_NEW_BO]     = st_q.new_bo;
            st_d.rdata[swgc_pkg::GC0_RSVD6]      = swgc_pkg::RSVD6_VAL;
            st_d.rdata[swgc_pkg::GC0_DYN_FLUSH]  = dyn_flush_act;
            st_d.rdata[swgc_pkg::GC0_STAT_FLUSH] = stat_flush_act;
            st_d.rdata[swgc_pkg::GC0_RSVD3]      = swgc_pkg::RSVD3_VAL;
            st_d.rdata[swgc_pkg::GC0_RSVD2]      = swgc_pkg::RSVD2_VAL;
            st_d.rdata[swgc_pkg::GC0_INTEROP]    = st_q.interop_flow_drop_mode;
            st_d.rdata[swgc_pkg::GC0_LINK_AGE]   = st_q.link_age;
        end
        if (RD && (ADDR == swgc_pkg::ADDR_GC1))
        begin
            st_d.rdata[swgc_pkg::GC1_PASS_ALL] = st_q.pass_all;
            st_d.rdata[swgc_pkg::GC1_HUGE]     = st_q.huge;
        end

        // Dynamic walker: one index per cycle, verdict one cycle later
        st_d.dyn_chk     = st_q.dyn_busy;
        st_d.dyn_chk_idx = st_q.dyn_idx;
        if (st_q.dyn_busy)
        begin
            if (st_q.dyn_idx == DYN_LAST)
            begin
                st_d.dyn_busy = 1'b0;
            end
            st_d.dyn_idx = st_q.dyn_idx + DW'(1);
        end
        else if (!st_q.dyn_chk && st_q.dyn_pend_age)
        begin
            // Fast age ahead of flush: it carries a deadline
            st_d.dyn_busy     = 1'b1;
            st_d.dyn_all      = 1'b1;
            st_d.dyn_idx      = '0;
            st_d.dyn_pend_age = 1'b0;
        end
        else if (!st_q.dyn_chk && st_q.dyn_pend_flush)
        begin
            st_d.dyn_busy       = 1'b1;
            st_d.dyn_all        = 1'b0;
            st_d.dyn_idx        = '0;
            st_d.dyn_pend_flush = 1'b0;
        end
        if (st_q.dyn_chk && DYN_ENT_VALID
            && (st_q.dyn_all || LEARN_DIS[DYN_ENT_PORT]))
        begin
            st_d.dyn_del     = 1'b1;
            st_d.dyn_del_idx = st_q.dyn_chk_idx;
        end
        if (st_q.dyn_chk && st_q.dyn_all && (st_q.dyn_chk_idx == DYN_LAST))
        begin
            st_d.age_restart = 1'b1;
        end
        // Requests after the hand-off: a new event is never lost
        if (wr_gc0 && WDATA[swgc_pkg::GC0_DYN_FLUSH])
        begin
            st_d.dyn_pend_flush = 1'b1;
        end
        if (st_q.link_age && (link_fall != '0))
        begin
            st_d.dyn_pend_age = 1'b1;
        end
        st_d.fa_cnt = fast_age_act ? st_q.fa_cnt + 32'h1 : 32'h0;

        // Static walker; a trigger while running is absorbed
        st_d.stat_chk     = st_q.stat_busy;
        st_d.stat_chk_idx = st_q.stat_idx;
        if (st_q.stat_busy)
        begin
            if (st_q.stat_idx == STAT_LAST)
            begin
                st_d.stat_busy = 1'b0;
            end
            st_d.stat_idx = st_q.stat_idx + SW'(1);
        end
        else if (!st_q.stat_chk && wr_gc0 && WDATA[swgc_pkg::GC0_STAT_FLUSH])
        begin
            st_d.stat_busy = 1'b1;
            st_d.stat_idx  = '0;
        end
        if (st_q.stat_chk && stat_hit)
        begin
            st_d.stat_del     = 1'b1;
            st_d.stat_del_idx = st_q.stat_chk_idx;
        end

        // Frame verdict; pass-all does not override pause drops
        st_d.frm_done      = FRM_VALID;
        st_d.frm_drop      = FRM_VALID && (fc_match || (err_frame && !st_q.pass_all));
        st_d.frm_sniff_bad = FRM_VALID && err_frame && st_q.pass_all && SNIFF_EN;
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    swgc_age_timer #(
        .PERIOD (AGE_CYC)
    ) u_age_timer (
        .clk     (MCLK),
        .rst_n   (RST_N),
        .restart (st_q.age_restart),
        .tick    (AGE_TICK)
    );

    assign RDATA           = st_q.rdata;
    assign NEW_BACKOFF_EN  = st_q.new_bo;
    assign PASS_ALL_FRAMES = st_q.pass_all;
    assign HUGE_FRAME_EN   = st_q.huge;
    assign DYN_RD_EN       = st_q.dyn_busy;
    assign DYN_RD_IDX      = st_q.dyn_idx;
    assign DYN_DEL         = st_q.dyn_del;
    assign DYN_DEL_IDX     = st_q.dyn_del_idx;
    assign STAT_RD_EN      = st_q.stat_busy;
    assign STAT_RD_IDX     = st_q.stat_idx;
    assign STAT_DEL        = st_q.stat_del;
    assign STAT_DEL_IDX    = st_q.stat_del_idx;
    assign FRM_DONE        = st_q.frm_done;
    assign FRM_DROP        = st_q.frm_drop;
    assign FRM_SNIFF_BAD   = st_q.frm_sniff_bad;

    default clocking a_cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    a_backoff_write: assert property (
        wr_gc0 |=> NEW_BACKOFF_EN == $past(WDATA[swgc_pkg::GC0_NEW_BO]))
        else $error("back-off enable did not follow write");
    a_dyn_start: assert property (
        wr_gc0 && WDATA[swgc_pkg::GC0_DYN_FLUSH] && !fast_age_act && !dyn_flush_act
        |=> dyn_flush_act ##1 (dyn_flush_act && DYN_RD_EN && DYN_RD_IDX == '0))
        else $error("dynamic flush did not start");
    a_dyn_select: assert property (
        DYN_DEL |-> $past(st_q.dyn_chk) && $past(DYN_ENT_VALID)
        && ($past(st_q.dyn_all) || $past(LEARN_DIS[DYN_ENT_PORT])))
        else $error("dynamic entry removed without cause");
    a_stat_start: assert property (
        wr_gc0 && WDATA[swgc_pkg::GC0_STAT_FLUSH] && !stat_flush_act
        |=> STAT_RD_EN && STAT_RD_IDX == '0 ##1 STAT_RD_IDX == SW'(1))
        else $error("static flush did not start");
    a_stat_qualify: assert property (STAT_DEL |-> $past(stat_hit))
        else $error("static entry removed without qualifying");
    a_stat_every: assert property (
        st_q.stat_chk && stat_hit |=> STAT_DEL && STAT_DEL_IDX == $past(st_q.stat_chk_idx))
        else $error("qualifying static entry kept");
    a_interop_drop: assert property (
        FRM_VALID && st_q.interop_flow_drop_mode && FRM_TYPE == swgc_pkg::FC_TYPE
        |=> FRM_DONE && FRM_DROP)
        else $error("interop frame not dropped");
    a_fc_only: assert property (
        FRM_VALID && !st_q.interop_flow_drop_mode && !FRM_IS_FC && !FRM_BAD
        && FRM_LEN <= swgc_pkg::FRAME_MAX_STD |=> FRM_DONE && !FRM_DROP)
        else $error("non flow control frame dropped");
    a_fast_age_time: assert property (st_q.fa_cnt < 32'(FAST_LIMIT))
        else $error("fast age exceeded its deadline");
    a_age_reload: assert property (st_q.age_restart |=> !AGE_TICK [*2])
        else $error("aging period not reloaded");
    a_pass_bad: assert property (
        FRM_VALID && st_q.pass_all && FRM_BAD && !fc_match |=> FRM_DONE && !FRM_DROP)
        else $error("errored frame dropped in pass-all");
    // Pass-all would keep an oversized frame, so it is left out here
    a_huge_len: assert property (
        FRM_VALID && !fc_match && !FRM_BAD && !st_q.pass_all
        && FRM_LEN == swgc_pkg::FRAME_MAX_HUGE |=> FRM_DROP == !$past(st_q.huge))
        else $error("2K frame verdict wrong");
    a_rsvd_read: assert property (
        RD && ADDR == swgc_pkg::ADDR_GC0 |=> RDATA[swgc_pkg::GC0_RSVD6] == swgc_pkg::RSVD6_VAL
        && RDATA[swgc_pkg::GC0_RSVD3] == swgc_pkg::RSVD3_VAL
        && RDATA[swgc_pkg::GC0_RSVD2] == swgc_pkg::RSVD2_VAL)
        else $error("reserved bits read wrong");
endmodule // swgc_regs

`default_nettype wire

// *** verilog/swgc_pkg.sv ***
// Purpose: Constants for the switch global control register block
// Assumes: 100 MHz system clock, byte-wide management register port
// Notes:   Summary of the behaviour is listed below
//
// Summary of operation
// - GC0 bit 7 selects the alternative back-off; clear means standard back-off.
// - Writing 1 to GC0 bit 5 starts a dynamic table flush; self-clearing.
// - Dynamic flush removes entries of learning-disabled ports only.
// - Writing 1 to GC0 bit 4 starts a static table flush; self-clearing.
// - Static entry qualifies if unicast, single forward port, port learning disabled.
// - Static flush removes every qualifying entry, several per port included.
// - Interop drop mode drops type 0x8808 or DA 01-80-C2-00-00-01.
// - Interop drop mode clear drops only qualified flow control frames.
// - GC0 bit 0 set: link loss triggers fast aging finishing under 800 us.
// - After the fast age cycle, aging returns to the 300 s period.
// - Port unplugged: all addresses are aged out of the table.
// - GC1 bit 7 forwards errored frames too; flow control frames are still dropped.
// - Pass-all-frames works together with sniffer mirroring.
// - GC1 bit 6 enables 2K byte frames; reset value 0.

package swgc_pkg;
    localparam logic [7:0]  ADDR_GC0       = 8'h02;
    localparam logic [7:0]  ADDR_GC1       = 8'h03;
    localparam int          GC0_NEW_BO     = 7;
    localparam int          GC0_RSVD6      = 6;
    localparam int          GC0_DYN_FLUSH  = 5;
    localparam int          GC0_STAT_FLUSH = 4;
    localparam int          GC0_RSVD3      = 3;
    localparam int          GC0_RSVD2      = 2;
    localparam int          GC0_INTEROP    = 1;
    localparam int          GC0_LINK_AGE   = 0;
    localparam int          GC1_PASS_ALL   = 7;
    localparam int          GC1_HUGE       = 6;
    localparam logic        RSVD6_VAL      = 1'h0;
    localparam logic        RSVD3_VAL      = 1'h1;
    localparam logic        RSVD2_VAL      = 1'h1;
    localparam logic [7:0]  RD_UNMAPPED    = 8'h00;
    localparam logic [15:0] FC_TYPE        = 16'h8808;
    localparam logic [47:0] FC_DA          = 48'h0180_C200_0001;
    localparam int          MCAST_BIT      = 40;
    localparam logic [11:0] FRAME_MAX_STD  = 12'h5F2;
    localparam logic [11:0] FRAME_MAX_HUGE = 12'h800;
    localparam longint unsigned CLK_HZ            = 100000000;
    localparam longint unsigned AGE_PERIOD_S      = 300;
    localparam longint unsigned AGE_PERIOD_CYC    = AGE_PERIOD_S * CLK_HZ;
    localparam longint unsigned FAST_AGE_LIMIT_US = 800;
    // Longest time: rounded down
    localparam longint unsigned FAST_AGE_MAX_CYC  = FAST_AGE_LIMIT_US * CLK_HZ / 1000000;
endpackage : swgc_pkg

// *** verilog/swgc_age_timer.sv ***
// Purpose: Normal aging period timer
// Assumes: Period in system clock cycles, at least 2
// Notes:   Restart reloads the period after a fast age cycle
`timescale 1ns/1ps
`default_nettype none

module swgc_age_timer #(
    parameter longint unsigned PERIOD = swgc_pkg::AGE_PERIOD_CYC
) (
    input  wire logic clk,       // System clock
    input  wire logic rst_n,     // Async reset, active low
    input  wire logic restart,   // Start a fresh period
    output logic      tick       // One-cycle aging pulse
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } swgc_tmr_t;

    swgc_tmr_t st_q;
    swgc_tmr_t st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (restart)
        begin
            st_d.cnt = '0;
        end
        else if (st_q.cnt == LAST)
        begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule // swgc_age_timer

`default_nettype wire

// *** test/swgc_regs_tb.sv ***
// Purpose: Self-checking bench for the switch global control registers
// Assumes: Shrunk dynamic table depth and aging counts; tables modelled here
// Notes:   Random frames and table contents from one fixed seed
`timescale 1ns/1ps
`default_nettype none

module swgc_regs_tb;
    localparam int DD = 16;
    localparam int SD = 32;
    localparam int AC = 50;
    logic        MCLK, RST_N, WR, RD, FRM_VALID, FRM_IS_FC, FRM_BAD, SNIFF_EN;
    logic        DYN_ENT_VALID, STAT_ENT_VALID, NEW_BACKOFF_EN, PASS_ALL_FRAMES;
    logic        HUGE_FRAME_EN, DYN_RD_EN, DYN_DEL, STAT_RD_EN, STAT_DEL, AGE_TICK;
    logic        FRM_DONE, FRM_DROP, FRM_SNIFF_BAD;
    logic [7:0]  ADDR, WDATA, RDATA, g0, g1, rv;
    logic [3:0]  LINK_UP, LEARN_DIS, STAT_ENT_PORTS, DYN_RD_IDX, DYN_DEL_IDX;
    logic [1:0]  DYN_ENT_PORT, vd;
    logic [4:0]  STAT_RD_IDX, STAT_DEL_IDX;
    logic [15:0] FRM_TYPE, dv, dexp;
    logic [47:0] FRM_DA, STAT_ENT_MAC;
    logic [11:0] FRM_LEN;
    logic [31:0] sv, sexp;
    logic [1:0]  dp [DD];
    logic [47:0] sm [SD];
    logic [3:0]  sp [SD];
    int          err_count, cmp_count, n;

    swgc_regs #(.NP(4), .DYN_DEPTH(DD), .STAT_DEPTH(SD), .AGE_CYC(AC), .FAST_LIMIT(64))
        swgc_regs_inst (.MCLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .NEW_BACKOFF_EN,
        .PASS_ALL_FRAMES, .HUGE_FRAME_EN, .LINK_UP, .LEARN_DIS, .DYN_RD_EN, .DYN_RD_IDX,
        .DYN_ENT_VALID, .DYN_ENT_PORT, .DYN_DEL, .DYN_DEL_IDX, .STAT_RD_EN, .STAT_RD_IDX,
        .STAT_ENT_VALID, .STAT_ENT_MAC, .STAT_ENT_PORTS, .STAT_DEL, .STAT_DEL_IDX,
        .AGE_TICK, .FRM_VALID, .FRM_TYPE, .FRM_DA, .FRM_IS_FC, .FRM_BAD, .FRM_LEN,
        .SNIFF_EN, .FRM_DONE, .FRM_DROP, .FRM_SNIFF_BAD);

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // Table memories answer one cycle after the index; removals clear valid
    always @(posedge MCLK)
    begin
        DYN_ENT_VALID <= DYN_RD_EN & dv[DYN_RD_IDX];
        DYN_ENT_PORT <= dp[DYN_RD_IDX];
        STAT_ENT_VALID <= STAT_RD_EN & sv[STAT_RD_IDX];
        STAT_ENT_MAC <= sm[STAT_RD_IDX];
        STAT_ENT_PORTS <= sp[STAT_RD_IDX];
        if (DYN_DEL) dv[DYN_DEL_IDX] <= 1'b0;
        if (STAT_DEL) sv[STAT_DEL_IDX] <= 1'b0;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        WR <= 1'b1; ADDR <= a; WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        RD <= 1'b1; ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask

    // Poll a busy bit; bounded so a stuck flush shows as a mismatch
    task automatic wait_clear(input int b);
        rd(8'h02, rv);
        chk("busy", 1, rv[b]);
        for (n = 0; n < 60 && rv[b] !== 1'b0; n++) rd(8'h02, rv);
        chk("busy end", 0, rv[b]);
    endtask

    task automatic fill();
        @(posedge MCLK);
        for (int i = 0; i < SD; i++)
        begin
            sm[i] <= 48'({$urandom, $urandom});
            sp[i] <= (i % 3 == 0) ? 4'h1 << (i % 4) : 4'($urandom);
            if (i < DD) dp[i] <= 2'($urandom);
        end
        dv <= 16'($urandom); sv <= $urandom; LEARN_DIS <= 4'($urandom);
        @(posedge MCLK);
        for (int i = 0; i < SD; i++)
        begin
            sexp[i] = sv[i] & !(!sm[i][40] && $onehot(sp[i]) && (sp[i] & LEARN_DIS) != 0);
            if (i < DD) dexp[i] = dv[i] & !LEARN_DIS[dp[i]];
        end
    endtask

    function automatic logic [1:0] verdict(input logic [7:0] c0, input logic [7:0] c1);
        logic m;
        logic big;
        m = c0[1] ? (FRM_TYPE == swgc_pkg::FC_TYPE || FRM_DA == swgc_pkg::FC_DA) : FRM_IS_FC;
        big = FRM_LEN > (c1[6] ? swgc_pkg::FRAME_MAX_HUGE : swgc_pkg::FRAME_MAX_STD);
        return {m | ((FRM_BAD | big) & !c1[7]), c1[7] & SNIFF_EN & (FRM_BAD | big)};
    endfunction

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #200us;
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        {RST_N, WR, RD, FRM_VALID, FRM_IS_FC, FRM_BAD, SNIFF_EN} = '0;
        {ADDR, WDATA, FRM_TYPE, FRM_DA, FRM_LEN} = '0;
        LINK_UP = 4'hF; LEARN_DIS = 4'h0; dv = '0; sv = '0;
        err_count = 0; cmp_count = 0;
        void'($urandom(32'h4420EDFB));
        repeat (3) @(posedge MCLK);
        RST_N <= 1'b1;
        rd(8'h02, rv); chk("gc0 reset", 8'h0C, rv);
        rd(8'h03, rv); chk("gc1 reset", 8'h00, rv);
        wr(8'h04, 8'hFF); rd(8'h04, rv); chk("unmapped", 8'h00, rv);
        $display("Test reset and map done");
        for (int i = 0; i < 200; i++)
        begin
            if (i % 20 == 0)
            begin
                g0 = 8'($urandom) & 8'hCE; g1 = 8'($urandom);
                wr(8'h02, g0); wr(8'h03, g1);
                rd(8'h02, rv); chk("gc0", (g0 & 8'h82) | 8'h0C, rv);
                rd(8'h03, rv); chk("gc1", g1 & 8'hC0, rv);
                chk("backoff", g0[7], NEW_BACKOFF_EN);
                chk("pass", g1[7], PASS_ALL_FRAMES);
                chk("huge", g1[6], HUGE_FRAME_EN);
            end
            @(posedge MCLK);
            FRM_VALID <= 1'b1; FRM_TYPE <= i[0] ? swgc_pkg::FC_TYPE : 16'($urandom);
            FRM_DA <= i[1] ? swgc_pkg::FC_DA : 48'({$urandom, $urandom});
            {FRM_IS_FC, FRM_BAD, SNIFF_EN} <= 3'($urandom);
            FRM_LEN <= (i % 4 == 0) ? 12'(i[3] ? 2048 : 1522) + 12'(i[2]) : 12'(1400 + $urandom % 700);
            @(posedge MCLK);
            FRM_VALID <= 1'b0;
            vd = verdict(g0, g1);
            #1 chk("done", 1, FRM_DONE);
            chk("drop", vd[1], FRM_DROP);
            chk("sniff", vd[0], FRM_SNIFF_BAD);
        end
        $display("Test frames done");
        fill(); wr(8'h02, 8'h20); wait_clear(5);
        chk("dyn table", dexp, dv);
        fill(); wr(8'h02, 8'h10); wait_clear(4);
        chk("stat table", sexp, sv);
        $display("Test flushes done");
        wr(8'h02, 8'h01); fill();
        dv <= 16'hFFFF; LINK_UP <= 4'hE;
        for (n = 0; n < 120 && dv !== 16'h0; n++) @(posedge MCLK);
        chk("fast age", 16'h0, dv);
        LINK_UP <= 4'hF;
        n = 0;
        repeat (500) @(posedge MCLK) n += AGE_TICK;
        chk("age ticks", 1, n >= 500 / AC - 1 && n <= 500 / AC + 1);
        $display("Test aging done");
        tally_and_finish();
    end
endmodule // swgc_regs_tb

`default_nettype wire
